//--- hw/crd_rd_target.sv
/*
  Bus target for address-less sequential reads. SCL and SDA are sampled by
  clk_i (25 MHz); bytes are prefetched from storage into a 16-entry FIFO and
  shifted out on SDA. Assumes storage answers rd_data_i combinationally for
  rd_addr_o on the same clock, and that the addressed-access logic moves the
  shared pointer through ptr_load_i / ptr_val_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "crd_params.svh"
module crd_rd_target (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic ptr_load_i,
  input wire logic [7:0] ptr_val_i,
  output logic [7:0] ptr_o
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  // Two flops per pin before any logic; third flop only for edges
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ==========================================================
  // Sequencer
  crd_pkg::crd_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic sda_oe_q;
  logic [7:0] ptr_q;
  logic [7:0] fetch_q;

  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out;

  wire match_rd = (sh_q == `CRD_ADDR_RD);
  wire match_wr = (sh_q == `CRD_ADDR_WR);
  wire byte_in = (cnt_q == `CRD_BITS_PER_BYTE);
  wire tx_last = (cnt_q == `CRD_LAST_BIT);
  wire load_byte = (st_q == crd_pkg::CRD_ACK) & rd_q & scl_fall;
  wire pop = load_byte & fifo_out_valid;
  wire reading = rd_q & ((st_q == crd_pkg::CRD_ACK) | (st_q == crd_pkg::CRD_TX) | (st_q == crd_pkg::CRD_RACK));
  wire flush = ~reading;
  wire [7:0] fetch_data = (fetch_q == `CRD_RSVD_LOC) ? `CRD_RSVD_VAL : rd_data_i;
  wire push = reading & fifo_in_ready;

  // Start and stop win over any state; stop always releases SDA
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= crd_pkg::CRD_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (bus_start)
    begin
      st_q <= crd_pkg::CRD_ADDR;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_q <= crd_pkg::CRD_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        crd_pkg::CRD_ADDR:
        begin
          if (scl_rise && !byte_in)
          begin
            sh_q <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall && byte_in)
          begin
            // Only our two address forms are answered
            st_q <= (match_rd | match_wr) ? crd_pkg::CRD_ACK : crd_pkg::CRD_IDLE;
            sda_oe_q <= match_rd | match_wr;
            rd_q <= match_rd;
          end
        end
        crd_pkg::CRD_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q <= 4'h0;
            if (rd_q && fifo_out_valid)
            begin
              // Host is receiver from here on
              st_q <= crd_pkg::CRD_TX;
              sh_q <= fifo_out[7:0];
              sda_oe_q <= ~fifo_out[7];
            end
            else
            begin
              // Write traffic belongs to other logic; an empty buffer aborts
              st_q <= rd_q ? crd_pkg::CRD_IDLE : crd_pkg::CRD_IGNORE;
              sda_oe_q <= 1'b0;
            end
          end
        end
        crd_pkg::CRD_TX:
        begin
          if (scl_fall)
          begin
            if (tx_last)
            begin
              st_q <= crd_pkg::CRD_RACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        crd_pkg::CRD_RACK:
        begin
          if (scl_rise)
          begin
            // Low acknowledge asks for more, high ends our driving
            st_q <= sda_s_q ? crd_pkg::CRD_IDLE : crd_pkg::CRD_ACK;
          end
        end
        crd_pkg::CRD_IDLE, crd_pkg::CRD_IGNORE:
        begin
          sda_oe_q <= 1'b0;
        end
        default:
        begin
          st_q <= crd_pkg::CRD_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Shared pointer and prefetch address
  // Pointer follows bytes actually sent, not bytes prefetched, so a
  // flushed prefetch never skips a location.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ptr_q <= `CRD_PTR_RST;
      fetch_q <= `CRD_PTR_RST + 8'h01;
    end
    else
    begin
      if (pop)
        ptr_q <= fifo_out[15:8];
      else if (ptr_load_i && !reading)
        ptr_q <= ptr_val_i;
      if (flush)
        fetch_q <= (ptr_load_i ? ptr_val_i : ptr_q) + 8'h01;
      else if (push)
        fetch_q <= fetch_q + 8'h01;
    end
  end

  crd_fifo #(
    .W(`CRD_FIFO_W),
    .D(`CRD_FIFO_D)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(flush),
    .in_valid_i(reading),
    .in_ready_o(fifo_in_ready),
    .in_data_i({fetch_q, fetch_data}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(load_byte),
    .out_data_o(fifo_out)
  );

  // Open-drain data pin: only ever pulls low
  always_ff @(posedge clk_i)
  begin
    sda_o <= 1'b0;
  end

  assign sda_oe_o = sda_oe_q;
  assign rd_addr_o = fetch_q;
  assign ptr_o = ptr_q;

  // ==========================================================
  // Checks
  property p_ack_match;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_q == crd_pkg::CRD_ADDR && scl_fall && byte_in && match_rd && !bus_start && !bus_stop) |=> sda_oe_o;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("read address not acknowledged");

  property p_no_foreign_ack;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_q == crd_pkg::CRD_ADDR && scl_fall && byte_in && !match_rd && !match_wr)
      |=> !sda_oe_o && st_q == crd_pkg::CRD_IDLE;
  endproperty
  a_no_foreign_ack: assert property (p_no_foreign_ack) else $error("foreign address acknowledged");

  // Every byte sent, the first of a read included, comes from one past the pointer
  property p_first_byte;
    @(posedge clk_i) disable iff (sys_rst_i)
    pop |-> fifo_out[15:8] == ptr_q + 8'h01;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("byte not from pointer plus one");

  property p_next_byte;
    @(posedge clk_i) disable iff (sys_rst_i)
    pop |=> ptr_q == $past(fifo_out[15:8]) && fifo_out[15:8] != $past(fifo_out[15:8]) || !fifo_out_valid;
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("pointer did not follow sent byte");

  property p_nack_release;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_q == crd_pkg::CRD_RACK && scl_rise && sda_s_q && !bus_start && !bus_stop)
      |=> !sda_oe_o [*3];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("data driven after high acknowledge");

  property p_reserved;
    @(posedge clk_i) disable iff (sys_rst_i)
    (pop && fifo_out[15:8] == `CRD_RSVD_LOC) |-> fifo_out[7:0] == `CRD_RSVD_VAL;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved location not FFh");

  property p_ptr_keep;
    @(posedge clk_i) disable iff (sys_rst_i)
    (bus_stop && !ptr_load_i) |=> ptr_q == $past(ptr_q);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer lost at stop");
endmodule
`default_nettype wire

//--- hw/crd_params.svh
/*
  Constants for the current-address read target: bus addresses, the reserved
  location, pointer reset value and FIFO shape.
  Assumes it is included by bare name from files under hw/.
*/
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH

// ==========================================================
// Bus addressing
`define CRD_ADDR_RD 8'h51
`define CRD_ADDR_WR 8'h50
`define CRD_BITS_PER_BYTE 4'h8
`define CRD_LAST_BIT 4'h7

// ==========================================================
// Storage map
`define CRD_RSVD_LOC 8'h07
`define CRD_RSVD_VAL 8'hff
`define CRD_PTR_RST 8'h00

// ==========================================================
// Prefetch buffer: {address, data} per entry
`define CRD_FIFO_W 16
`define CRD_FIFO_D 16

`endif

//--- hw/crd_pkg.sv
/*
  Types shared by the current-address read target.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package crd_pkg;
  // Bus-side sequencer states
  typedef enum logic [2:0] {
    CRD_IDLE,
    CRD_ADDR,
    CRD_ACK,
    CRD_TX,
    CRD_RACK,
    CRD_IGNORE
  } crd_state_e;
endpackage
`default_nettype wire

//--- hw/crd_fifo.sv
/*
  Synchronous FIFO in flip-flops with valid/ready on both sides and a flush.
  Assumes both sides run on clk_i; flush drops every entry in one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module crd_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // Honest full and empty straight from the occupancy count
  assign in_ready_o = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // ==========================================================
  // Pointers and count
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

//--- bench/crd_host_model.sv
/*
  Behavioural bus host for the read target: start, stop, byte out, byte in.
  Assumes the bench resolves SDA from all pull-downs with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module crd_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ==========================================
  // Bus idles high; SCL stands still outside frames
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Quarter bit is two system clocks, so a bit lasts 320 ns
  task automatic qtr();
    repeat (2) @(posedge clk_i);
  endtask

  // Data set while SCL is low, sampled mid high phase, well after the target moves
  task automatic put_bit(input logic b, output logic s);
    sda_low_o <= ~b;
    qtr();
    scl_o <= 1'b1;
    qtr();
    s = sda_i;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  // ==========================================
  // Framing
  task automatic start();
    sda_low_o <= 1'b1;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  task automatic stop();
    sda_low_o <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_low_o <= 1'b0;
    qtr();
  endtask

  // Byte out MSB first, then release SDA for the target's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, ack);
  endtask

  // Byte in with SDA released; low acknowledge asks for more, high ends
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(last, s);
  endtask
endmodule
`default_nettype wire

//--- bench/crd_rd_target_tb_top.sv
/*
  Self-checking bench for the read target: host model on the bus and a
  storage array behind the read port.
  Assumes the design's own assertions run alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "crd_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module crd_rd_target_tb_top;
  typedef struct packed {logic [7:0] ptr; logic [7:0] n; logic [7:0] end_ptr;} crd_row_s;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, sda_low, sda_o, sda_oe_o;
  logic ptr_load_i = 1'b0;
  logic [7:0] ptr_val_i = 8'h00;
  logic [7:0] rd_addr_o, rd_data_i, ptr_o;
  int checks = 0;
  int n_fail = 0;
  int cyc = 0;
  // Wraps, the reserved location and a single byte
  crd_row_s rows [4] = '{'{8'h00, 8'h03, 8'h03}, '{8'h05, 8'h04, 8'h09},
                         '{8'hfe, 8'h03, 8'h01}, '{8'h10, 8'h01, 8'h11}};
  logic [7:0] bad_addr [3] = '{8'h52, 8'h71, `CRD_ADDR_WR};
  logic bad_ack [3] = '{1'b1, 1'b1, 1'b0};
  // Wired-AND bus with pull-up: released SDA reads high
  wire logic sda = ~(sda_low | (sda_oe_o & ~sda_o));

  // ==========================================
  // Clock, storage, instances
  always #20 clk_i = ~clk_i;
  assign rd_data_i = rd_addr_o ^ 8'h5a; // Reserved slot holds junk so its override shows

  crd_rd_target i_crd_rd_target (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .ptr_load_i(ptr_load_i), .ptr_val_i(ptr_val_i), .ptr_o(ptr_o));
  crd_host_model i_crd_host_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    return (a == `CRD_RSVD_LOC) ? `CRD_RSVD_VAL : a ^ 8'h5a;
  endfunction

  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic load_ptr(input logic [7:0] v);
    ptr_load_i <= 1'b1;
    ptr_val_i <= v;
    @(posedge clk_i);
    ptr_load_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Full address-less read of n bytes, the last one answered high
  task automatic do_read(input logic [7:0] first, input int n);
    logic ack;
    logic [7:0] d;
    i_crd_host_model.start();
    i_crd_host_model.send_byte(`CRD_ADDR_RD, ack);
    `CHK(ack, 1'b0)
    for (int k = 0; k < n; k++)
    begin
      i_crd_host_model.get_byte(k == n - 1, d);
      `CHK(d, exp_byte(first + 8'(k)))
    end
    repeat (4) @(posedge clk_i);
    `CHK(sda_oe_o, 1'b0)
    i_crd_host_model.stop();
  endtask

  // ==========================================
  // Hang guard: whole run needs a few thousand cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================
  // Main sequence
  initial
  begin
    logic ack;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (int r = 0; r < 4; r++)
    begin
      load_ptr(rows[r].ptr);
      do_read(rows[r].ptr + 8'h01, int'(rows[r].n));
      `CHK(ptr_o, rows[r].end_ptr)
    end
    // No load between reads: the pointer carries over the stop
    do_read(8'h12, 2);
    `CHK(ptr_o, 8'h13)
    // Foreign addresses get no acknowledge; the write address does
    for (int b = 0; b < 3; b++)
    begin
      i_crd_host_model.start();
      i_crd_host_model.send_byte(bad_addr[b], ack);
      `CHK(ack, bad_ack[b])
      i_crd_host_model.stop();
    end
    `CHK(ptr_o, 8'h13)
    // A pointer load during a read is ignored; the read runs on from the last byte
    fork
      do_read(8'h14, 2);
      begin
        repeat (100) @(posedge clk_i);
        load_ptr(8'h80);
      end
    join
    `CHK(ptr_o, 8'h15)
    // Second reset mid-run on an idle bus
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(sda_oe_o, 1'b0)
    `CHK(sda_o, 1'b0)
    `CHK(ptr_o, `CRD_PTR_RST)
    `CHK(rd_addr_o, `CRD_PTR_RST + 8'h01)
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    do_read(`CRD_PTR_RST + 8'h01, 2);
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
